// file: logic/mres_event_select.v
/*
 * Event selection and qualification for eight performance counters
 * watching the memory pipeline, with an APB register file.
 * Assumes event inputs are one-cycle pulses synchronous to pclk.
 */
`timescale 1ns/100ps
`include "mres_consts.vh"

module mres_event_select #(
    parameter NUM_CNT = 8
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        load_split_done,
    input  wire        store_split_done,
    input  wire        load_port_split_replay,
    input  wire        store_port_split_replay,
    input  wire        unknown_store_addr_replay,
    input  wire        unknown_store_data_replay,
    input  wire        cache_miss_pulse,
    input  wire        uncacheable_access_pulse,
    output reg         all_cache_miss_pulse,
    output reg  [11:0] counter_inc
);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    reg  [31:0]          split_access_select_reg_a;
    reg  [31:0]          split_access_select_reg_b;
    reg  [31:0]          ordering_buffer_select_reg_a;
    reg  [31:0]          ordering_buffer_select_reg_b;
    reg  [4*NUM_CNT-1:0] counter_config_control_reg;
    reg  [NUM_CNT-1:0]   status_reg;
    wire [NUM_CNT-1:0]   hit;
    wire                 setup;
    wire                 wr_en;
    wire                 cfg_hit;
    wire [2:0]           cfg_idx;
    reg                  mapped;
    reg  [31:0]          rd_word;

    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pwrite;
    assign pready  = 1'b1;
    assign cfg_hit = (paddr >= `MRES_OFS_CFG_BASE) && (paddr <= `MRES_OFS_CFG_LAST)
                     && (paddr[1:0] == 2'b00);
    assign cfg_idx = paddr[4:2];
    assign pslverr = psel & penable & ~mapped;

    // ****************************************************************
    // Address decode and read mux
    // ****************************************************************
    always @* begin
        mapped  = 1'b1;
        rd_word = `MRES_RESET_WORD;
        case (paddr)
            `MRES_OFS_SPLIT_A: rd_word = split_access_select_reg_a;
            `MRES_OFS_SPLIT_B: rd_word = split_access_select_reg_b;
            `MRES_OFS_ORDER_A: rd_word = ordering_buffer_select_reg_a;
            `MRES_OFS_ORDER_B: rd_word = ordering_buffer_select_reg_b;
            `MRES_OFS_STATUS:  rd_word = {{(32-NUM_CNT){1'b0}}, status_reg};
            default: begin
                if (cfg_hit) begin
                    rd_word[`MRES_SEL_HI:`MRES_SEL_LO] =
                        counter_config_control_reg[4*cfg_idx+1 +: 3];
                    rd_word[`MRES_EN_BIT] = counter_config_control_reg[4*cfg_idx];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // Read data is captured in the setup cycle, valid in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `MRES_RESET_WORD;
        end else if (setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            split_access_select_reg_a    <= `MRES_RESET_WORD;
            split_access_select_reg_b    <= `MRES_RESET_WORD;
            ordering_buffer_select_reg_a <= `MRES_RESET_WORD;
            ordering_buffer_select_reg_b <= `MRES_RESET_WORD;
        end else if (wr_en) begin
            case (paddr)
                `MRES_OFS_SPLIT_A: split_access_select_reg_a    <= pwdata;
                `MRES_OFS_SPLIT_B: split_access_select_reg_b    <= pwdata;
                `MRES_OFS_ORDER_A: ordering_buffer_select_reg_a <= pwdata;
                `MRES_OFS_ORDER_B: ordering_buffer_select_reg_b <= pwdata;
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Event vectors by code, indexed by mask bit
    // ****************************************************************
    wire [15:0] complete_bits;
    wire [15:0] ld_replay_bits;
    wire [15:0] st_replay_bits;
    wire [15:0] ob_replay_bits;

    assign complete_bits  = ({15'h0000, load_split_done} << `MRES_BIT_LD_SPLIT) // R04
                          | ({15'h0000, store_split_done} << `MRES_BIT_ST_SPLIT); // R04
    assign ld_replay_bits = {15'h0000, load_port_split_replay} << `MRES_BIT_LD_REPLAY; // R06
    assign st_replay_bits = {15'h0000, store_port_split_replay} << `MRES_BIT_ST_REPLAY; // R07
    assign ob_replay_bits = ({15'h0000, unknown_store_addr_replay} << `MRES_BIT_NO_ADDR) // R10
                          | ({15'h0000, unknown_store_data_replay} << `MRES_BIT_NO_DATA); // R10

    // ****************************************************************
    // Per-counter qualification
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < NUM_CNT; i = i + 1) begin : g_cnt
            wire [31:0] sel_word;
            wire [6:0]  code;
            wire [15:0] mask;
            reg  [15:0] evt;
            wire [2:0]  cfg_sel;
            wire        cfg_en;
            wire        is_split;

            // Low four counters belong to the ordering buffer, the rest to split access
            assign is_split = (i >= 4);
            assign sel_word = is_split ?
                ((i % 4) < 2 ? split_access_select_reg_a : split_access_select_reg_b) : // R05
                ((i % 4) < 2 ? ordering_buffer_select_reg_a    // R09
                             : ordering_buffer_select_reg_b);  // R09
            assign code    = sel_word[`MRES_CODE_HI:`MRES_CODE_LO];
            assign mask    = sel_word[`MRES_MASK_HI:`MRES_MASK_LO];
            assign cfg_sel = counter_config_control_reg[4*i+1 +: 3];
            assign cfg_en  = counter_config_control_reg[4*i];

            always @* begin
                evt = 16'h0000;
                if (is_split) begin
                    case (code)
                        `MRES_CODE_COMPLETE:  evt = complete_bits;  // R02
                        `MRES_CODE_LD_REPLAY: evt = ld_replay_bits; // R06
                        `MRES_CODE_ST_REPLAY: evt = st_replay_bits; // R07
                        default:              evt = 16'h0000;
                    endcase
                end else if (code == `MRES_CODE_OB_REPLAY) begin
                    evt = ob_replay_bits; // R09
                end
            end

            assign hit[i] = cfg_en && (cfg_sel == `MRES_SEL_MEMORY) // R11
                            && ((evt & mask) != 16'h0000); // R03

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    counter_config_control_reg[4*i +: 4] <= 4'h0;
                    status_reg[i] <= 1'b0;
                end else begin
                    if (wr_en && cfg_hit && cfg_idx == i) begin
                        counter_config_control_reg[4*i +: 4] <=
                            {pwdata[`MRES_SEL_HI:`MRES_SEL_LO], pwdata[`MRES_EN_BIT]};
                    end
                    // Sticky hit flag, write one to clear, a new hit wins
                    if (hit[i]) begin
                        status_reg[i] <= 1'b1;
                    end else if (wr_en && paddr == `MRES_OFS_STATUS && pwdata[i]) begin
                        status_reg[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Increment pulses to counters 0-3 and 8-11
    // ****************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_inc          <= 12'h000;
            all_cache_miss_pulse <= 1'b0;
        end else begin
            counter_inc          <= {hit[7:4], 4'h0, hit[3:0]}; // R05
            all_cache_miss_pulse <= cache_miss_pulse | uncacheable_access_pulse; // R01
        end
    end

endmodule

// file: logic/mres_consts.vh
/*
 * Constants for the memory replay event selection block: register
 * offsets, field positions, event codes and mask bit positions.
 * Assumes it is included once per compile unit by its bare name.
 */
//
// Summary of operation
// R01: The all-cache-miss count also includes accesses to uncacheable memory.
// R02: Event code 08h in select bits 31:25 counts load and store split completions.
// R03: Software sets mask bits 24:9; any matching selected bit counts.
// R04: Completion mask bit 0 counts cacheable load splits, bit 1 split stores.
// R05: Split select register A drives counters 8 and 9, B drives 10 and 11.
// R06: Code 04h counts load port replays; mask bit 1 split loads; select 02h.
// R07: Code 05h counts store port replays; mask bit 1 split stores; select 02h.
// R08: Software uses select register B for at-retirement port replay counts.
// R09: Code 03h counts ordering buffer replays; A drives 0,1, B drives 2,3.
// R10: Ordering buffer mask bit 1 unknown store address, bit 3 unknown data.
// R11: Count only when code, config select and an enabled mask bit all match.
`ifndef MRES_CONSTS_VH
`define MRES_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MRES_OFS_SPLIT_A    12'h000
`define MRES_OFS_SPLIT_B    12'h004
`define MRES_OFS_ORDER_A    12'h008
`define MRES_OFS_ORDER_B    12'h00c
`define MRES_OFS_STATUS     12'h010
`define MRES_OFS_CFG_BASE   12'h020
`define MRES_OFS_CFG_LAST   12'h03c

// ****************************************************************
// Field positions
// ****************************************************************
`define MRES_CODE_HI        31
`define MRES_CODE_LO        25
`define MRES_MASK_HI        24
`define MRES_MASK_LO        9
`define MRES_SEL_HI         15
`define MRES_SEL_LO         13
`define MRES_EN_BIT         12

// ****************************************************************
// Event codes, config select and mask bits
// ****************************************************************
`define MRES_CODE_COMPLETE  7'h08
`define MRES_CODE_LD_REPLAY 7'h04
`define MRES_CODE_ST_REPLAY 7'h05
`define MRES_CODE_OB_REPLAY 7'h03
`define MRES_SEL_MEMORY     3'h2
`define MRES_BIT_LD_SPLIT   0
`define MRES_BIT_ST_SPLIT   1
`define MRES_BIT_LD_REPLAY  1
`define MRES_BIT_ST_REPLAY  1
`define MRES_BIT_NO_ADDR    1
`define MRES_BIT_NO_DATA    3
`define MRES_RESET_WORD     32'h00000000

`endif

// file: testbench/mres_monitor.sv
/* Checker on the event ports of the selection block.
   Assumes it is bound into mres_event_select. */
`timescale 1ns/100ps
module mres_monitor (
    input wire        pclk,
    input wire        presetn,
    input wire        load_split_done,
    input wire        store_split_done,
    input wire        load_port_split_replay,
    input wire        store_port_split_replay,
    input wire        unknown_store_addr_replay,
    input wire        unknown_store_data_replay,
    input wire        cache_miss_pulse,
    input wire        uncacheable_access_pulse,
    input wire        all_cache_miss_pulse,
    input wire [11:0] counter_inc
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_no_split;
        !load_split_done && !store_split_done &&
        !load_port_split_replay && !store_port_split_replay;
    endsequence
    sequence s_no_ob;
        !unknown_store_addr_replay && !unknown_store_data_replay;
    endsequence
    property p_acm; all_cache_miss_pulse ==
        ($past(cache_miss_pulse) || $past(uncacheable_access_pulse)); endproperty
    a_acm: assert property (p_acm) else $error("bad miss pulse");
    property p_uc; uncacheable_access_pulse |=> all_cache_miss_pulse; endproperty
    a_uc: assert property (p_uc) else $error("uc not in miss");
    property p_cm; cache_miss_pulse |=> all_cache_miss_pulse; endproperty
    a_cm: assert property (p_cm) else $error("miss lost");
    property p_hole; counter_inc[7:4] == 4'h0; endproperty
    a_hole: assert property (p_hole) else $error("bad counter");
    property p_no_split; s_no_split |=> counter_inc[11:8] == 4'h0; endproperty
    a_no_split: assert property (p_no_split) else $error("split count");
    property p_no_ob; s_no_ob |=> counter_inc[3:0] == 4'h0; endproperty
    a_no_ob: assert property (p_no_ob) else $error("ob count");
    property p_quiet; (s_no_split and s_no_ob) |=> counter_inc == 12'h000; endproperty
    a_quiet: assert property (p_quiet) else $error("idle count");
    property p_ob_src; |counter_inc[3:0] |->
        $past(unknown_store_addr_replay) || $past(unknown_store_data_replay); endproperty
    a_ob_src: assert property (p_ob_src) else $error("ob cause");
endmodule
bind mres_event_select mres_monitor u_mon (.*);

// file: testbench/mres_pipe_model.sv
/* Pipeline event source: registers a request vector onto the event inputs one cycle later.
   Assumes requests change just after a rising pclk edge. */
`timescale 1ns/100ps
module mres_pipe_model (
    input  wire       pclk,
    input  wire [7:0] req,
    output reg  [7:0] ev
);
    initial ev = 8'h00;
    always @(posedge pclk) begin
        ev <= req;
    end
endmodule

// file: testbench/tb_top.sv
/* Bench for the event selection block: APB tasks and event scenarios.
   Assumes the pipeline model drives all event inputs. */
`timescale 1ns/100ps
module tb_top;
    reg         pclk = 1'b0;
    reg         presetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg  [7:0]  req = 8'h00;
    reg  [11:0] a;
    reg  [31:0] rd;
    reg         er;
    wire [7:0]  ev;
    wire        pready;
    wire        pslverr;
    wire [31:0] prdata;
    wire        all_cache_miss_pulse;
    wire [11:0] counter_inc;
    integer     err_count = 0;
    integer     checked = 0;
    initial forever #50 pclk = ~pclk;
    mres_pipe_model u_pipe (.pclk, .req, .ev);
    mres_event_select dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .pslverr, .prdata, .load_split_done(ev[0]), .store_split_done(ev[1]),
        .load_port_split_replay(ev[2]), .store_port_split_replay(ev[3]),
        .unknown_store_addr_replay(ev[4]), .unknown_store_data_replay(ev[5]),
        .cache_miss_pulse(ev[6]), .uncacheable_access_pulse(ev[7]),
        .all_cache_miss_pulse, .counter_inc);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
                err_count = err_count + 1;
            end
        end
    endtask
    task apb(input w, input [11:0] ad, input [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= ad;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rdc(input [11:0] ad, input [31:0] exp);
        begin
            apb(1'b0, ad, 32'h0);
            chk(rd, exp);
        end
    endtask
    task fire(input [7:0] v, input [12:0] exp);
        begin
            @(posedge pclk);
            req <= v;
            @(posedge pclk);
            req <= 8'h00;
            @(posedge pclk);
            #1 chk({19'h0, all_cache_miss_pulse, counter_inc}, {19'h0, exp});
        end
    endtask
    task summarize;
        begin
            if (err_count == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        repeat (3000) @(posedge pclk);
        err_count = err_count + 1;
        summarize;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h000, 32'h0);
        chk({31'h0, er}, 32'h0);
        rdc(12'h010, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        for (a = 12'h020; a <= 12'h03c; a = a + 12'h004) apb(1'b1, a, 32'h00005000);
        apb(1'b1, 12'h000, 32'h10000600);
        rdc(12'h000, 32'h10000600);
        fire(8'h02, 13'h0300);
        fire(8'h01, 13'h0300);
        fire(8'h04, 13'h0000);
        apb(1'b1, 12'h000, 32'h10000400);
        fire(8'h01, 13'h0000);
        fire(8'h03, 13'h0300);
        apb(1'b1, 12'h004, 32'h08000400);
        fire(8'h04, 13'h0c00);
        fire(8'h08, 13'h0000);
        apb(1'b1, 12'h004, 32'h0a000400);
        fire(8'h08, 13'h0c00);
        apb(1'b1, 12'h008, 32'h06000400);
        apb(1'b1, 12'h00c, 32'h06001000);
        fire(8'h10, 13'h0003);
        fire(8'h20, 13'h000c);
        fire(8'h12, 13'h0303);
        apb(1'b1, 12'h008, 32'h10000400);
        fire(8'h10, 13'h0000);
        apb(1'b1, 12'h030, 32'h00007000);
        rdc(12'h030, 32'h00007000);
        fire(8'h02, 13'h0200);
        apb(1'b1, 12'h034, 32'h00004000);
        fire(8'h02, 13'h0000);
        fire(8'h80, 13'h1000);
        fire(8'h40, 13'h1000);
        rdc(12'h010, 32'h000000ff);
        apb(1'b1, 12'h010, 32'h000000ff);
        rdc(12'h010, 32'h0);
        summarize;
    end
endmodule
